// ===== logic/fcm_bank.v
// control register bank of the digitally pulled oscillator
//
// Summary of operation
// - bits 15:11 of the high register read zero; writes to them ignored.
// - high register bit 10 gates the output driver; zero at reset.
// - in pin-controlled enable mode, the software enable bit has no effect.
// - high register bits 9:0 are the top ten pull word bits.
// - low register at zero holds the low sixteen pull word bits.
// - the whole 26-bit pull word is zero at power-up.
// - the pull word is a signed two's-complement value.
// - new pull word applied only on a high register write.
`timescale 1ns/1ns
`include "fcm_defines.vh"
module fcm_bank
#(
	parameter WORD_BITS = 26
)
(
	input  wire                        clk,
	input  wire                        reset_n,
	input  wire                        reg_wr,
	input  wire                        reg_rd,
	input  wire [7:0]                  reg_addr,
	input  wire [15:0]                 reg_wdata,
	output reg  [15:0]                 reg_rdata,
	output reg                         reg_rvalid,
	input  wire                        oe_from_pin,
	input  wire                        oe_pin,
	output wire signed [WORD_BITS-1:0] pull_control_word,
	output wire                        word_update,
	output wire                        output_enable,
	output wire [3:0]                  pull_range
);
	reg  [15:0]                low_pull_word;
	reg  [`FCM_HIGH_BITS-1:0]  high_pull_word;
	reg                        sw_oe;
	reg  [`FCM_RANGE_BITS-1:0] range_sel;
	reg  [15:0]                next_low_pull_word;
	reg  [`FCM_HIGH_BITS-1:0]  next_high_pull_word;
	reg                        next_sw_oe;
	reg  [`FCM_RANGE_BITS-1:0] next_range_sel;
	reg  [15:0]                next_rdata;
	wire                       low_hit;
	wire                       high_hit;
	wire                       range_hit;
	wire                       high_load;
	wire                       apply_oe;
	wire [WORD_BITS-1:0]       load_word;
	wire [WORD_BITS-1:0]       applied;

	////////////////////////////////////////////////////////////////////
	// address compare, shared by the write and the read path
	function fcm_addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			fcm_addr_hit = (addr == target);
		end
	endfunction

	// unused and unmapped bits always come back as zero
	function [15:0] fcm_read_mux;
		input [7:0]                 addr;
		input [15:0]                low_word;
		input                       oe_bit;
		input [`FCM_HIGH_BITS-1:0]  high_word;
		input [`FCM_RANGE_BITS-1:0] range_word;
		begin
			if (fcm_addr_hit(addr, `FCM_ADDR_LOW))
				fcm_read_mux = low_word;
			else if (fcm_addr_hit(addr, `FCM_ADDR_HIGH))
				fcm_read_mux = {5'h00, oe_bit, high_word};
			else if (fcm_addr_hit(addr, `FCM_ADDR_RANGE))
				fcm_read_mux = {12'h000, range_word};
			else
				fcm_read_mux = 16'h0000;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	assign low_hit    = fcm_addr_hit(reg_addr, `FCM_ADDR_LOW);
	assign high_hit   = fcm_addr_hit(reg_addr, `FCM_ADDR_HIGH);
	assign range_hit  = fcm_addr_hit(reg_addr, `FCM_ADDR_RANGE);
	assign high_load  = reg_wr && high_hit;
	assign pull_range = range_sel;

	////////////////////////////////////////////////////////////////////
	// writes to unmapped addresses fall through and change nothing
	always @*
	begin
		next_low_pull_word  = low_pull_word;
		next_high_pull_word = high_pull_word;
		next_sw_oe          = sw_oe;
		next_range_sel      = range_sel;
		if (reg_wr && low_hit)
			next_low_pull_word = reg_wdata;
		if (high_load)
		begin
			// bits 15:11 are never stored
			next_high_pull_word = reg_wdata[`FCM_HIGH_MSB:0];
			next_sw_oe          = reg_wdata[`FCM_OE_BIT];
		end
		if (reg_wr && range_hit)
			next_range_sel = reg_wdata[`FCM_RANGE_BITS-1:0];
	end

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			low_pull_word  <= `FCM_LOW_RESET;
			high_pull_word <= `FCM_HIGH_WORD_RESET;
			sw_oe          <= 1'b0;
			range_sel      <= `FCM_RANGE_RESET;
		end
		else
		begin
			low_pull_word  <= next_low_pull_word;
			high_pull_word <= next_high_pull_word;
			sw_oe          <= next_sw_oe;
			range_sel      <= next_range_sel;
		end
	end

	////////////////////////////////////////////////////////////////////
	// a read in the cycle of a write returns the old contents
	always @*
	begin
		next_rdata = reg_rdata;
		if (reg_rd)
			next_rdata = fcm_read_mux(reg_addr,
				low_pull_word,
				sw_oe,
				high_pull_word,
				range_sel);
	end

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			reg_rdata  <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// new high bits go in beside the stored low word, so the word is
	// only coherent when the host has written the low half first
	assign load_word = {reg_wdata[`FCM_HIGH_MSB:0], low_pull_word};
	// the enable bit of this very write reaches the driver with the word
	assign apply_oe  = high_load ? reg_wdata[`FCM_OE_BIT] : sw_oe;

	fcm_apply #(.WORD_BITS(WORD_BITS)) u_apply
	(
		.clk               (clk),
		.reset_n           (reset_n),
		.load              (high_load),
		.new_word          (load_word),
		.sw_oe             (apply_oe),
		.oe_from_pin       (oe_from_pin),
		.oe_pin            (oe_pin),
		.pull_control_word (applied),
		.word_update       (word_update),
		.output_enable     (output_enable)
	);

	// two's complement offset for the oscillator
	assign pull_control_word = applied;
endmodule

// ===== logic/fcm_defines.vh
// register offsets, field positions and reset values of the pull-word bank
`ifndef FCM_DEFINES_VH
`define FCM_DEFINES_VH
`define FCM_ADDR_LOW        8'h00
`define FCM_ADDR_HIGH       8'h01
`define FCM_ADDR_RANGE      8'h02
`define FCM_OE_BIT          10
`define FCM_HIGH_MSB        9
`define FCM_HIGH_BITS       10
`define FCM_LOW_BITS        16
`define FCM_WORD_BITS       26
`define FCM_RANGE_BITS      4
`define FCM_LOW_RESET       16'h0000
`define FCM_HIGH_RESET      16'h0000
`define FCM_HIGH_WORD_RESET 10'h000
`define FCM_RANGE_RESET     4'h0
`endif

// ===== logic/fcm_apply.v
// applied pull word and output-enable gating
`timescale 1ns/1ns
`include "fcm_defines.vh"
module fcm_apply
#(
	parameter WORD_BITS = 26
)
(
	input  wire                 clk,
	input  wire                 reset_n,
	input  wire                 load,
	input  wire [WORD_BITS-1:0] new_word,
	input  wire                 sw_oe,
	input  wire                 oe_from_pin,
	input  wire                 oe_pin,
	output reg  [WORD_BITS-1:0] pull_control_word,
	output reg                  word_update,
	output reg                  output_enable
);
	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			pull_control_word <= {WORD_BITS{1'b0}};
			word_update       <= 1'b0;
			output_enable     <= 1'b0;
		end
		else
		begin
			word_update <= load;
			// only a high-word load reaches the oscillator
			if (load)
				pull_control_word <= new_word;
			// pin mode ignores the software bit entirely
			output_enable <= oe_from_pin ? oe_pin : sw_oe;
		end
	end
endmodule

// ===== verification/fcm_host.sv
// host model driving the register strobes
`timescale 1ns/1ns
module fcm_host #(parameter GAP = 6580)
(input wire clk, output reg reg_wr, reg_rd,
 output reg [7:0] reg_addr, output reg [15:0] reg_wdata);
initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
task xfer(input w, input [7:0] a, input [15:0] d);
begin
	@(posedge clk);
	{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
	@(posedge clk);
	// released lines show junk, never the old value
	{reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
end
endtask
task pull(input [25:0] v, input b);
begin
	xfer(1, 8'h00, v[15:0]);
	xfer(1, 8'h01, {5'h1f, b, v[25:16]});
	// about 26 us between updates
	repeat (GAP) @(posedge clk);
end
endtask
endmodule

// ===== verification/fcm_bank_properties.sv
// assertions on the pull-word bank ports
`timescale 1ns/1ns
module fcm_props #(parameter WORD_BITS = 26)
(input wire clk, reset_n, reg_wr, reg_rd, oe_from_pin, oe_pin,
 input wire [7:0] reg_addr, input wire [15:0] reg_wdata, reg_rdata,
 input wire reg_rvalid, word_update, output_enable,
 input wire [3:0] pull_range,
 input wire signed [WORD_BITS-1:0] pull_control_word);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
wire hw = reg_wr && reg_addr == 8'h01;
reg [15:0] lw;
always @(posedge clk)
	lw <= !reset_n ? 16'h0000 : reg_wr && reg_addr == 8'h00 ? reg_wdata : lw;
a_update_hi: assert property (hw |=> word_update)
	else $error("no update");
a_no_update: assert property (!hw |=> !word_update && $stable(pull_control_word))
	else $error("stray update");
a_word_hi: assert property (hw |=> pull_control_word[25:16] == $past(reg_wdata[9:0]))
	else $error("high bits");
a_word_lo: assert property (hw |=> pull_control_word[15:0] == $past(lw))
	else $error("low bits");
a_rd_zero: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rvalid && reg_rdata[15:11] == 5'h00)
	else $error("unused bits");
a_sw_oe: assert property (hw && !oe_from_pin |=> output_enable == $past(reg_wdata[10]))
	else $error("sw enable");
a_pin_oe: assert property (oe_from_pin |=> output_enable == $past(oe_pin))
	else $error("pin enable");
a_reset_zero: assert property ($rose(reset_n) |-> pull_control_word == 0 && !output_enable)
	else $error("reset state");
endmodule
bind fcm_bank fcm_props #(.WORD_BITS(WORD_BITS)) fcm_props_inst (.clk, .reset_n,
	.reg_wr, .reg_rd, .oe_from_pin, .oe_pin, .reg_addr, .reg_wdata, .reg_rdata,
	.reg_rvalid, .word_update, .output_enable, .pull_range, .pull_control_word);

// ===== verification/tb_fcm_bank.sv
// self-checking bench for the pull-word bank
`timescale 1ns/1ns
module tb_fcm_bank;
reg clk = 0, reset_n = 0, oe_from_pin = 0, oe_pin = 0;
wire reg_wr, reg_rd, reg_rvalid, word_update, output_enable;
wire [7:0] reg_addr;
wire [15:0] reg_wdata, reg_rdata;
wire [3:0] pull_range;
wire signed [25:0] pull_control_word;
integer err_count = 0, n_checks = 0, i;
logic [26:0] qw[$], qr[$], e;
logic [25:0] w;
logic o;
fcm_host fcm_host_inst (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
fcm_bank fcm_bank_inst (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_rdata, .reg_rvalid, .oe_from_pin, .oe_pin,
	.pull_control_word, .word_update, .output_enable, .pull_range);
initial forever #2 clk = ~clk;
task chk(input string n, input logic [26:0] s, x);
begin
	n_checks++;
	if (s !== x) begin err_count++; $display("mismatch %s exp %h got %h", n, x, s); end
end
endtask
task give_verdict;
begin
	$display("checks %0d mismatches %0d", n_checks, err_count);
	if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
end
endtask
// an empty queue yields x, so a stray result never matches
always @(posedge clk) if (reset_n) begin
	if (word_update) begin e = qw.size() ? qw.pop_front() : 'x; chk("word", {output_enable, pull_control_word}, e); end
	if (reg_rvalid) begin e = qr.size() ? qr.pop_front() : 'x; chk("rdata", reg_rdata, e); end
end
task rd(input [7:0] a, input [15:0] x); begin qr.push_back(x); fcm_host_inst.xfer(0, a, 0); end endtask
task pw(input [25:0] v, input b, x); begin qw.push_back({x, v}); fcm_host_inst.pull(v, b); end endtask
initial begin
	void'($urandom(46540));
	repeat (20) @(posedge clk);
	reset_n <= 1;
	rd(8'h01, 0);
	rd(8'h00, 0);
	$display("reset values done");
	for (i = 0; i < 4; i++) begin
		// i == 2: +90 in a 200 half range, scaled and rounded
		w = i == 0 ? 26'h2000000 : i == 1 ? 26'h1ffffff :
			i == 2 ? 26'((64'd90 * 64'd33554431 + 64'd100) / 64'd200) : $urandom;
		o = $urandom;
		pw(w, o, o);
		rd(8'h01, {5'h00, o, w[25:16]});
	end
	$display("pull updates done");
	fcm_host_inst.xfer(1, 8'h00, 16'h1234);
	rd(8'h00, 16'h1234);
	chk("hold", {1'b0, pull_control_word}, {1'b0, w});
	fcm_host_inst.xfer(1, 8'h05, 16'hffff);
	rd(8'h05, 0);
	fcm_host_inst.xfer(1, 8'h02, 16'hfffa);
	rd(8'h02, 16'h000a);
	chk("range", pull_range, 4'ha);
	$display("low-only and unmapped done");
	oe_from_pin <= 1;
	oe_pin <= 1;
	pw($urandom, 0, 1);
	oe_pin <= 0;
	repeat (3) @(posedge clk);
	chk("pin enable", output_enable, 0);
	pw($urandom, 1, 0);
	$display("pin enable done");
	give_verdict;
end
initial begin #240000; err_count++; give_verdict; end
endmodule
